// file: hw/servo_vibration_notch_filter_bank.sv
/*
 * Torque reference filter bank: low-pass, four notches, three band
 * suppressors, resonance detector, adaptive notches and periodic storage.
 * Assumes the speed loop offers samples with valid/ready and that software
 * drives the settings ports as static levels.
 */
`timescale 1ns/1ps
`default_nettype none
`include "notch_bank_map.svh"
module servo_vibration_notch_filter_bank #(
    parameter int              W             = 16,
    parameter int              SAMPLE_DIV    = `SAMPLE_DIV,
    parameter logic [15:0]     DET_THRESHOLD = 16'h0100,
    parameter longint unsigned STORE_CYCLES  = `STORE_MINUTES * `SECONDS_PER_MIN * `CLK_HZ
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  in_valid,
    output logic                       in_ready,
    input  wire logic [W-1:0]          in_torque,
    output logic                       out_valid,
    input  wire logic                  out_ready,
    output logic [W-1:0]               out_torque,
    input  wire logic                  servo_on,
    input  wire logic [2:0]            adaptive_notch_mode_select,
    input  wire logic [15:0]           torque_filter_time_constant,
    input  wire logic [3:0][12:0]      notch_freq,
    input  wire logic [3:0][4:0]       notch_width,
    input  wire logic [3:0][6:0]       notch_depth,
    input  wire logic [2:0][12:0]      sup_freq,
    input  wire logic [2:0][7:0]       sup_comp,
    input  wire logic [2:0][10:0]      sup_phase,
    output logic [12:0]                detected_resonance_frequency,
    output logic [1:0]                 adapt_active,
    output logic [1:0][12:0]           adapt_freq,
    output logic [1:0][4:0]            adapt_width,
    output logic [1:0][6:0]            adapt_depth,
    output logic                       store_strobe
);
    localparam int AW = W + 8;
    localparam int DW = $clog2(SAMPLE_DIV);

    // Refuse settings the arithmetic or counters cannot carry.
    if (W < 8 || W > 24 || SAMPLE_DIV < 2 || STORE_CYCLES < 1
        || STORE_CYCLES >= 64'h0000010000000000) begin : g_bad_params
        $error("notch bank: unsupported parameter values");
    end

    // Hertz to Q14 resonator coefficient; tenth selects 0.1 Hz units.
    function automatic logic [15:0] freq_coef(input logic [12:0] f, input logic tenth);
        logic [31:0] p;
        p = 32'(f) * 32'(tenth ? `FREQ_COEF_TENTH : `FREQ_COEF_HZ);
        return p[25:10];
    endfunction

    // Holds a nonzero frequency inside its band; zero leaves it off.
    function automatic logic [12:0] band_clip(input logic [12:0] f, input logic [12:0] lo,
                                              input logic [12:0] hi);
        if (f == 13'h000) begin
            return f;
        end else if (f < lo) begin
            return lo;
        end else if (f > hi) begin
            return hi;
        end
        return f;
    endfunction

    // Control period divider and the pending-sample flag.
    logic [DW-1:0] div_ff;
    logic [DW-1:0] nxt_div;
    logic          due_ff;          // A control period awaits its sample.
    logic          nxt_due;
    logic          tick;            // One-cycle control period pulse.
    logic          take;            // Sample accepted this cycle.
    logic          pop;             // Output word leaves the buffer.

    // A new period outranks the acceptance that clears the flag.
    always_comb begin
        tick    = (div_ff == DW'(SAMPLE_DIV - 1));
        nxt_div = tick ? '0 : div_ff + 1'b1;
        nxt_due = tick | (due_ff & ~take);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= '0;
            due_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            due_ff <= nxt_due;
        end
    end

    // Two-entry output buffer; a full buffer stalls the speed loop.
    logic [1:0][W-1:0] buf_ff;
    logic [1:0][W-1:0] nxt_buf;
    logic              wp_ff;
    logic              rp_ff;
    logic              nxt_wp;
    logic              nxt_rp;
    logic [1:0]        cnt_ff;
    logic [1:0]        nxt_cnt;
    logic [W-1:0]      filt_out;    // Filtered sample of this cycle.

    assign in_ready   = due_ff && (cnt_ff != 2'h2);
    assign take       = in_valid && in_ready;
    assign out_valid  = (cnt_ff != 2'h0);
    assign pop        = out_valid && out_ready;
    assign out_torque = buf_ff[rp_ff];

    always_comb begin
        nxt_buf = buf_ff;
        if (take) begin
            nxt_buf[wp_ff] = filt_out;
        end
        nxt_wp  = wp_ff ^ take;
        nxt_rp  = rp_ff ^ pop;
        nxt_cnt = cnt_ff + {1'b0, take} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_ff <= '0;
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            buf_ff <= nxt_buf;
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end

    // First-order low-pass in Q8; gain Ts/(tau+Ts) with tau in 0.01 ms.
    notch_bank_pkg::wide_t lpf_a;   // Q16 smoothing gain.
    notch_bank_pkg::wide_t lpf_new; // State after this sample.
    logic signed [AW-1:0]  lpf_ff;
    logic signed [AW-1:0]  nxt_lpf;

    always_comb begin
        lpf_a   = notch_bank_pkg::to_wide(`LPF_NUM
                  / (32'(torque_filter_time_constant) * 32'h0000000A + `LPF_TS_US));
        lpf_new = notch_bank_pkg::wide_t'(lpf_ff)
                  + (((notch_bank_pkg::wide_t'($signed(in_torque)) <<< 8)
                  - notch_bank_pkg::wide_t'(lpf_ff)) * lpf_a >>> 16);
        nxt_lpf = take ? AW'(lpf_new) : lpf_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lpf_ff <= '0;
        end else begin
            lpf_ff <= nxt_lpf;
        end
    end

    // Adaptive notch state, used below to pick the notch settings.
    logic [1:0][12:0] a_freq_ff;
    logic [1:0][4:0]  a_wid_ff;
    logic [1:0][6:0]  a_dep_ff;
    logic [1:0]       own_ff;       // Notch is under adaptive control.

    // Settings per stage: software values, or the adaptive ones once owned.
    logic [3:0][15:0] n_coef;
    logic [3:0][15:0] n_damp;
    logic [3:0][6:0]  n_dep;
    logic [3:0]       n_byp;
    logic [3:0][12:0] n_f;
    logic [2:0][15:0] s_coef;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            n_f[i]    = notch_freq[i];
            n_damp[i] = {5'h00, notch_width[i], 6'h00};
            n_dep[i]  = notch_depth[i];
            if (i >= 2 && own_ff[i[0]]) begin
                n_f[i]    = a_freq_ff[i[0]];
                n_damp[i] = {5'h00, a_wid_ff[i[0]], 6'h00};
                n_dep[i]  = a_dep_ff[i[0]];
            end
            // Width level / 4 is the damping, i.e. bandwidth over centre.
            n_coef[i] = freq_coef(n_f[i], 1'b0);
            n_byp[i]  = (n_f[i] == `NOTCH_BYPASS_HZ);
        end
        s_coef[0] = freq_coef(band_clip(sup_freq[0], `UPPER_BAND_LO, `UPPER_BAND_HI), 1'b0);
        s_coef[1] = freq_coef(band_clip(sup_freq[1], `MIDDLE_BAND_LO, `UPPER_BAND_LO), 1'b0);
        s_coef[2] = freq_coef(band_clip(sup_freq[2], 13'h001, `LOWER_BAND_HI), 1'b1);
    end

    // Notch cascade fed by the low-pass, suppressors beside it.
    logic signed [W-1:0]  chain [5];
    logic signed [AW-1:0] s_lo [3];
    logic signed [AW-1:0] s_bp [3];

    assign chain[0] = W'(lpf_new >>> 8);

    for (genvar g = 0; g < 4; g++) begin : g_notch
        svf_stage #(.W(W)) u_notch (
            .clk    (clk),
            .rst_n  (rst_n),
            .step   (take),
            .x      (chain[g]),
            .f_coef (n_coef[g]),
            .damp   (n_damp[g]),
            .depth  (n_dep[g]),
            .bypass (n_byp[g]),
            .y      (chain[g+1]),
            .lo     (),
            .bp     ()
        );
    end

    for (genvar g = 0; g < 3; g++) begin : g_sup
        svf_stage #(.W(W)) u_sup (
            .clk    (clk),
            .rst_n  (rst_n),
            .step   (take),
            .x      (chain[0]),
            .f_coef (s_coef[g]),
            .damp   (`SUP_DAMP),
            .depth  (`DEPTH_DEFAULT),
            .bypass (1'b0),
            .y      (),
            .lo     (s_lo[g]),
            .bp     (s_bp[g])
        );
    end

    // Compensation: band-pass plus a phase-steering low-pass share, scaled.
    notch_bank_pkg::wide_t comp_sum;
    notch_bank_pkg::wide_t shifted;

    always_comb begin
        comp_sum = '0;
        shifted  = '0;
        for (int i = 0; i < 3; i++) begin
            shifted  = notch_bank_pkg::wide_t'(s_bp[i]) + notch_bank_pkg::scale_frac(
                       notch_bank_pkg::wide_t'(s_lo[i]), 16'(sup_phase[i]), `PHASE_RECIP);
            comp_sum = comp_sum + notch_bank_pkg::scale_frac(shifted, 16'(sup_comp[i]),
                       `PCT_RECIP);
        end
        filt_out = W'(notch_bank_pkg::clip(notch_bank_pkg::wide_t'(chain[4]) - comp_sum, W));
    end

    // Resonance detector: period between rising crossings of the slope.
    notch_bank_pkg::det_state_t st_ff;
    notch_bank_pkg::det_state_t nxt_st;
    logic [W-1:0]               prev_ff;    // Previous input sample.
    logic                       neg_ff;     // Previous slope was negative.
    logic [15:0]                per_ff;     // Samples since last crossing.
    logic [15:0]                peak_ff;    // Largest slope magnitude seen.
    logic [15:0]                nxt_per;
    logic [15:0]                nxt_peak;
    logic                       nxt_neg;
    notch_bank_pkg::wide_t      slope;
    logic [15:0]                mag;
    logic                       rise;
    logic                       hit;        // A resonance period was measured.
    logic [31:0]                quo;
    logic [12:0]                det_f;

    always_comb begin
        slope    = notch_bank_pkg::wide_t'($signed(in_torque))
                   - notch_bank_pkg::wide_t'($signed(prev_ff));
        mag      = 16'(notch_bank_pkg::clip(slope < 0 ? -slope : slope, 17));
        rise     = take && neg_ff && (slope >= 0);
        nxt_neg  = take ? (slope < 0) : neg_ff;
        nxt_st   = st_ff;
        nxt_per  = per_ff;
        nxt_peak = peak_ff;
        hit      = 1'b0;
        quo      = `SAMPLE_RATE_HZ / {16'h0000, (per_ff == 16'h0000) ? 16'h0001 : per_ff};
        det_f    = (quo > 32'(`NOTCH_BYPASS_HZ)) ? `NOTCH_BYPASS_HZ
                 : (quo < 32'(`NOTCH_MIN_HZ)) ? `NOTCH_MIN_HZ : quo[12:0];
        case (st_ff)
            notch_bank_pkg::DET_SEEK: begin
                if (rise) begin
                    nxt_st   = notch_bank_pkg::DET_MEASURE;
                    nxt_per  = 16'h0001;
                    nxt_peak = 16'h0000;
                end
            end
            default: begin
                if (rise) begin
                    hit      = (peak_ff >= DET_THRESHOLD);
                    nxt_per  = 16'h0001;
                    nxt_peak = 16'h0000;
                end else if (take) begin
                    nxt_per  = per_ff + 16'h0001;
                    nxt_peak = (mag > peak_ff) ? mag : peak_ff;
                    // A period this long is no resonance; start over.
                    if (per_ff == 16'hFFFE) begin
                        nxt_st = notch_bank_pkg::DET_SEEK;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff   <= notch_bank_pkg::DET_SEEK;
            prev_ff <= '0;
            neg_ff  <= 1'b0;
            per_ff  <= 16'h0000;
            peak_ff <= 16'h0000;
        end else begin
            st_ff   <= nxt_st;
            prev_ff <= take ? in_torque : prev_ff;
            neg_ff  <= nxt_neg;
            per_ff  <= nxt_per;
            peak_ff <= nxt_peak;
        end
    end

    // Adaptive notch control and the detected frequency report.
    logic             m_one;
    logic             m_two;
    logic             m_adapt;
    logic             sel;          // Adaptive notch that takes the hit.
    logic [1:0][12:0] nxt_af;
    logic [1:0][4:0]  nxt_aw;
    logic [1:0][6:0]  nxt_ad;
    logic [1:0]       nxt_own;
    logic [12:0]      det_ff;
    logic [12:0]      nxt_det;

    always_comb begin
        m_one   = (adaptive_notch_mode_select == `MODE_ONE);
        m_two   = (adaptive_notch_mode_select == `MODE_TWO);
        m_adapt = m_one | m_two;
        nxt_af  = a_freq_ff;
        nxt_aw  = a_wid_ff;
        nxt_ad  = a_dep_ff;
        nxt_own = own_ff | {m_two, m_adapt};
        // A hit near the third notch, or with it idle, retunes the third.
        sel     = m_two && (a_freq_ff[0] != `NOTCH_BYPASS_HZ)
                  && ((det_f > a_freq_ff[0] ? det_f - a_freq_ff[0]
                  : a_freq_ff[0] - det_f) >= {2'b00, a_freq_ff[0][12:2]});
        nxt_det = (hit && servo_on && (m_adapt
                  || adaptive_notch_mode_select == `MODE_MEASURE)) ? det_f : det_ff;
        if (adaptive_notch_mode_select == `MODE_CLEAR) begin
            nxt_af  = {2{`NOTCH_BYPASS_HZ}};
            nxt_aw  = {2{`WIDTH_DEFAULT}};
            nxt_ad  = {2{`DEPTH_DEFAULT}};
            nxt_own = 2'b00;
        end else if (hit && servo_on && m_adapt) begin
            nxt_af[sel] = det_f;
            nxt_aw[sel] = `WIDTH_DEFAULT;
            // Deepen step by step while the resonance persists.
            if (a_freq_ff[sel] == `NOTCH_BYPASS_HZ) begin
                nxt_ad[sel] = `ADAPT_DEPTH_START;
            end else if (a_dep_ff[sel] != 7'h00) begin
                nxt_ad[sel] = a_dep_ff[sel] - 7'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_freq_ff <= {2{`NOTCH_BYPASS_HZ}};
            a_wid_ff  <= {2{`WIDTH_DEFAULT}};
            a_dep_ff  <= {2{`DEPTH_DEFAULT}};
            own_ff    <= 2'b00;
            det_ff    <= 13'h000;
        end else begin
            a_freq_ff <= nxt_af;
            a_wid_ff  <= nxt_aw;
            a_dep_ff  <= nxt_ad;
            own_ff    <= nxt_own;
            det_ff    <= nxt_det;
        end
    end

    // Storage interval timer; servo off or leaving adaptation restarts it.
    logic [39:0] tmr_ff;
    logic [39:0] nxt_tmr;
    logic        store_ff;
    logic        nxt_store;
    logic        tmr_end;

    always_comb begin
        tmr_end   = (tmr_ff == 40'(STORE_CYCLES - 1));
        nxt_store = servo_on && m_adapt && tmr_end;
        nxt_tmr   = (!servo_on || !m_adapt || tmr_end) ? 40'h0000000000 : tmr_ff + 40'h0000000001;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_ff   <= 40'h0000000000;
            store_ff <= 1'b0;
        end else begin
            tmr_ff   <= nxt_tmr;
            store_ff <= nxt_store;
        end
    end

    assign detected_resonance_frequency = det_ff;
    assign adapt_active = own_ff;
    assign adapt_freq   = a_freq_ff;
    assign adapt_width  = a_wid_ff;
    assign adapt_depth  = a_dep_ff;
    assign store_strobe = store_ff;
endmodule
`default_nettype wire

// file: hw/notch_bank_map.svh
/*
 * Constant map of the notch filter bank: defaults, mode codes, scaling
 * factors, band edges and timing figures.
 * Assumes a 10 MHz clock; included by bare name, definitions only.
 */
`ifndef NOTCH_BANK_MAP_SVH
`define NOTCH_BANK_MAP_SVH
// Clock rate in hertz.
`define CLK_HZ            64'h0000000000989680
// Clocks per control period and the resulting sample rate in hertz.
`define SAMPLE_DIV        32'h00000140
`define SAMPLE_RATE_HZ    32'h00007A12
// Centre value that bypasses a notch, and the detector's output range.
`define NOTCH_BYPASS_HZ   13'hFA0
`define NOTCH_MIN_HZ      13'h032
// Reset values of the width and depth levels.
`define WIDTH_DEFAULT     5'h02
`define DEPTH_DEFAULT     7'h00
// Depth level that passes the centre frequency fully.
`define DEPTH_PASS        16'h0064
// Depth given to a freshly placed adaptive notch.
`define ADAPT_DEPTH_START 7'h32
// Adaptive notch mode codes.
`define MODE_HOLD         3'h0
`define MODE_ONE          3'h1
`define MODE_TWO          3'h2
`define MODE_MEASURE      3'h3
`define MODE_CLEAR        3'h4
// Storage interval.
`define STORE_MINUTES     64'h000000000000001E
`define SECONDS_PER_MIN   64'h000000000000003C
// Hertz to Q14 coefficient, times 1024; the second for 0.1 Hz units.
`define FREQ_COEF_HZ      16'h0D2D
`define FREQ_COEF_TENTH   16'h0151
// Reciprocals in Q16 of 100 and of 1600.
`define PCT_RECIP         16'h028F
`define PHASE_RECIP       16'h0029
// First-order low-pass: sample period in microseconds, Q16 numerator.
`define LPF_TS_US         32'h00000020
`define LPF_NUM           32'h00200000
// Fixed damping of a suppressor resonator, Q8.
`define SUP_DAMP          16'h0040
// Suppressor band edges in hertz, the lower band in 0.1 Hz.
`define UPPER_BAND_LO     13'h1F4
`define UPPER_BAND_HI     13'h320
`define MIDDLE_BAND_LO    13'h12C
`define LOWER_BAND_HI     13'h0BB7
`endif

// file: hw/notch_bank_pkg.sv
/*
 * Types and shared arithmetic of the notch filter bank.
 * Assumes signed samples of at most 24 bits, so 64-bit math never wraps.
 */
package notch_bank_pkg;
    // Wide signed working type for all filter arithmetic.
    typedef logic signed [63:0] wide_t;
    // States of the resonance period detector.
    typedef enum logic [0:0] {DET_SEEK, DET_MEASURE} det_state_t;

    // Widens an unsigned value as a positive signed number.
    function automatic wide_t to_wide(input logic [31:0] v);
        return wide_t'(v);
    endfunction

    // Scales v by k times a Q16 reciprocal.
    function automatic wide_t scale_frac(input wide_t v, input logic [15:0] k,
                                         input logic [15:0] recip);
        return (v * to_wide(32'(k)) * to_wide(32'(recip))) >>> 16;
    endfunction

    // Saturates v to a signed field of the given width.
    function automatic wide_t clip(input wide_t v, input int bits);
        wide_t hi;
        hi = (wide_t'(1) <<< (bits - 1)) - wide_t'(1);
        if (v > hi) begin
            return hi;
        end else if (v < -hi - wide_t'(1)) begin
            return -hi - wide_t'(1);
        end
        return v;
    endfunction
endpackage

// file: hw/svf_stage.sv
/*
 * One state-variable filter section: notch output with depth control,
 * and low-pass and band-pass outputs for the suppressors.
 * Assumes step pulses once per accepted sample and coefficients stable then.
 */
`timescale 1ns/1ps
`default_nettype none
`include "notch_bank_map.svh"
module svf_stage #(
    parameter int W = 16
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                step,
    input  wire logic signed [W-1:0] x,
    input  wire logic [15:0]         f_coef,
    input  wire logic [15:0]         damp,
    input  wire logic [6:0]          depth,
    input  wire logic                bypass,
    output logic signed [W-1:0]      y,
    output logic signed [W+7:0]      lo,
    output logic signed [W+7:0]      bp
);
    localparam int AW = W + 8;

    notch_bank_pkg::wide_t xw;      // Input sample, widened.
    notch_bank_pkg::wide_t qbp;     // Damped band-pass term.
    notch_bank_pkg::wide_t hp;      // High-pass node.
    notch_bank_pkg::wide_t nlo;     // Updated low-pass state.
    notch_bank_pkg::wide_t nbp;     // Updated band-pass state.
    notch_bank_pkg::wide_t rej;     // Part of the band removed from x.
    logic signed [AW-1:0]  lo_ff;   // Low-pass integrator.
    logic signed [AW-1:0]  bp_ff;   // Band-pass integrator.
    logic signed [AW-1:0]  nxt_lo;
    logic signed [AW-1:0]  nxt_bp;

    // Chamberlin update; states saturate so a wide notch cannot wrap.
    always_comb begin
        xw  = notch_bank_pkg::wide_t'(x);
        qbp = (notch_bank_pkg::wide_t'(bp_ff) * notch_bank_pkg::to_wide(32'(damp))) >>> 8;
        nlo = notch_bank_pkg::clip(notch_bank_pkg::wide_t'(lo_ff)
              + ((notch_bank_pkg::to_wide(32'(f_coef)) * notch_bank_pkg::wide_t'(bp_ff)) >>> 14),
              AW);
        hp  = xw - nlo - qbp;
        nbp = notch_bank_pkg::clip(notch_bank_pkg::wide_t'(bp_ff)
              + ((notch_bank_pkg::to_wide(32'(f_coef)) * hp) >>> 14), AW);
        // Depth 0 removes the whole centre component, 100 removes none.
        rej = notch_bank_pkg::scale_frac(qbp, `DEPTH_PASS - 16'(depth), `PCT_RECIP);
        nxt_lo = step ? AW'(nlo) : lo_ff;
        nxt_bp = step ? AW'(nbp) : bp_ff;
    end

    // A bypassed stage hands the sample on untouched.
    assign y  = bypass ? x : W'(notch_bank_pkg::clip(xw - rej, W));
    assign lo = AW'(nlo);
    assign bp = AW'(nbp);

    // Integrator registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_ff <= '0;
            bp_ff <= '0;
        end else begin
            lo_ff <= nxt_lo;
            bp_ff <= nxt_bp;
        end
    end
endmodule
`default_nettype wire

// file: sim/notch_bank_assertions.sv
/* Port checker of the filter bank.
   Assumes the period divider starts at zero on reset release; bound from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module notch_bank_assertions #(
    parameter int PERIOD = 8
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             in_valid,
    input wire logic             in_ready,
    input wire logic             out_valid,
    input wire logic             servo_on,
    input wire logic [2:0]       adaptive_notch_mode_select,
    input wire logic [1:0]       adapt_active,
    input wire logic [1:0][12:0] adapt_freq,
    input wire logic             store_strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A sample is taken when both handshake lines are high.
    wire logic take = in_valid && in_ready;
    wire logic [2:0] md = adaptive_notch_mode_select;
    // Mirror of the period divider; a take on a tick edge leaves the next sample due.
    logic [15:0] ph_ff;
    logic        due_ff;
    wire logic   tick = (ph_ff == 16'(PERIOD - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_ff  <= 16'h0000;
            due_ff <= 1'b0;
        end else begin
            ph_ff  <= tick ? 16'h0000 : ph_ff + 16'h0001;
            due_ff <= tick | (due_ff & ~take);
        end
    end
    property p_drop; take && !tick |=> !in_ready; endproperty
    a_drop: assert property (p_drop) else $error("ready held after take");
    property p_out; take |=> out_valid; endproperty
    a_out: assert property (p_out) else $error("no word after take");
    property p_gap; take |-> due_ff; endproperty
    a_gap: assert property (p_gap) else $error("two takes in a period");
    property p_one; store_strobe |=> !store_strobe; endproperty
    a_one: assert property (p_one) else $error("store pulse too long");
    property p_run; store_strobe |-> $past(servo_on); endproperty
    a_run: assert property (p_run) else $error("store while off");
    property p_hold; md == 3'h0 |=> $stable(adapt_freq); endproperty
    a_hold: assert property (p_hold) else $error("held notch moved");
    property p_meas; md == 3'h3 |=> $stable(adapt_active) && $stable(adapt_freq); endproperty
    a_meas: assert property (p_meas) else $error("notch moved in measure");
    property p_single; md == 3'h1 && !adapt_active[1] |=> !adapt_active[1]; endproperty
    a_single: assert property (p_single) else $error("fourth notch taken");
    c_take: cover property (take ##1 out_valid);
    c_store: cover property (store_strobe);
    c_adapt: cover property ($rose(adapt_active[0]));
endmodule
`default_nettype wire

// file: sim/speed_loop_model.sv
/* Speed loop source: triangle torque of 16 samples.
   Drives on the falling edge; a word stands until it is taken. */
`timescale 1ns/1ps
`default_nettype none
module speed_loop_model (
    input  wire logic  clk,
    input  wire logic  in_ready,
    input  wire logic  slow,
    output logic       in_valid,
    output logic [15:0] in_torque
);
    logic [3:0] n = 4'h0;
    logic       taken = 1'b1;
    initial in_valid = 1'b0;
    always @(posedge clk) taken <= in_valid && in_ready;
    // A word changes only once it was taken or while no word is offered.
    always @(negedge clk) if (taken || !in_valid) begin
        n <= n + 4'h1;
        in_valid <= !(slow && $urandom_range(1));
        in_torque <= {4'h0, n[3] ? ~n[2:0] : n[2:0], 9'h000} - 16'h0800;
    end
endmodule
`default_nettype wire

// file: sim/servo_vibration_notch_filter_bank_tb_top.sv
/* Bench of the filter bank with a source model and a stalling sink.
   Assumes an 8-clock period and a 200-clock store interval. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) n_compared++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s exp %0h got %0h", s, e, g); end
module servo_vibration_notch_filter_bank_tb_top;
    logic clk = 0, rst_n = 0, slow = 0, out_ready = 0, servo_on = 0, chk = 0;
    logic in_valid, in_ready, out_valid, strobe;
    logic [2:0] mode = 3'h0;
    logic [15:0] in_torque, out_torque, w, tau = 16'h0000;
    logic [12:0] det;
    logic [1:0] act;
    logic [1:0][12:0] af, af_s;
    logic [2:0][7:0] comp = '0;
    logic [2:0][10:0] ph = '0;
    logic [15:0] q[$];
    int num_errors = 0, n_compared = 0, n_str = 0;
    initial forever #50 clk = ~clk;
    speed_loop_model SRC (.clk, .in_ready, .slow, .in_valid, .in_torque);
    servo_vibration_notch_filter_bank #(.SAMPLE_DIV(8), .STORE_CYCLES(200)) DUT (
        .clk, .rst_n, .in_valid, .in_ready, .in_torque, .out_valid, .out_ready,
        .out_torque, .servo_on, .adaptive_notch_mode_select(mode),
        .torque_filter_time_constant(tau), .notch_freq({4{13'hFA0}}),
        .notch_width({4{5'h02}}), .notch_depth({4{7'h00}}), .sup_freq('0),
        .sup_comp(comp), .sup_phase(ph), .detected_resonance_frequency(det),
        .adapt_active(act), .adapt_freq(af), .adapt_width(), .adapt_depth(),
        .store_strobe(strobe));
    // Taken words are queued; with every stage bypassed they come out unchanged.
    always @(posedge clk) begin
        if (in_valid && in_ready) q.push_back(in_torque);
        if (out_valid && out_ready) begin
            w = q.pop_front();
            if (chk) begin `CHK("out_torque", w, out_torque) end
        end
        n_str += int'(strobe);
    end
    task automatic run(input int n);
        repeat (n) @(negedge clk) begin
            out_ready <= $urandom_range(3) != 0;
            comp <= {3{8'($urandom_range(100))}};
            ph <= {3{11'($urandom_range(1600))}};
        end
    endtask
    task automatic conclude();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #3000000 num_errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'h7CEE));
        repeat (16) @(negedge clk);
        `CHK("adapt_freq", {2{13'hFA0}}, af)
        rst_n = 1;
        chk = 1;
        run(400);
        // A long sink stall fills the buffer; no word may be lost.
        out_ready <= 0;
        repeat (60) @(negedge clk);
        slow = 1;
        run(300);
        chk = 0;
        slow = 0;
        servo_on = 1;
        mode = 3'h1;
        run(1500);
        `CHK("adapt_active", 2'h1, act)
        `CHK("store", 1'b1, n_str > 4)
        // The source triangle repeats every 16 samples: 31250 / 16 Hz.
        `CHK("adapt_freq", 13'h7A1, af[0])
        mode = 3'h0;
        af_s = af;
        run(300);
        `CHK("adapt_freq", af_s, af)
        mode = 3'h3;
        run(300);
        `CHK("adapt_freq", af_s, af)
        `CHK("detected", 13'h7A1, det)
        mode = 3'h1;
        n_str = 0;
        run(150);
        servo_on = 0;
        run(100);
        `CHK("store", 0, n_str)
        // Clearing hands both notches back to the bypassed software settings.
        mode = 3'h4;
        run(2);
        `CHK("adapt_active", 2'h0, act)
        `CHK("adapt_freq", {2{13'hFA0}}, af)
        conclude();
    end
endmodule
bind servo_vibration_notch_filter_bank notch_bank_assertions #(.PERIOD(SAMPLE_DIV)) CHKR (.clk, .rst_n,
    .in_valid, .in_ready, .out_valid, .servo_on, .adaptive_notch_mode_select,
    .adapt_active, .adapt_freq, .store_strobe);
`default_nettype wire
